// [pkg/rtc_regs_pkg.sv]
`default_nettype none
package rtc_regs_pkg;

    // --------------------------------------------------------------
    // Link register window
    // --------------------------------------------------------------
    localparam logic [3:0] STATUS_FLAGS_ADDR = 4'hE;
    localparam logic [3:0] DIV_TEST_ADDR = 4'hF;
    localparam int BUSY_BIT = 3;
    localparam int PERIODIC_BIT = 2;
    localparam int ALARM_BIT = 1;
    localparam int OSC_STOP_BIT = 0;
    localparam int TEST_A_BIT = 3;
    localparam int TEST_B_BIT = 2;
    localparam int DIV_RESET_BIT = 1;
    localparam logic TEST_SELECT_RESET = 1'b1;
    localparam logic [3:0] ZERO_NIBBLE = 4'h0;

    // --------------------------------------------------------------
    // Timing
    // --------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int BUSY_MAX_TIME_NS = 122100;
    localparam int BUSY_MAX_CYCLES = BUSY_MAX_TIME_NS / CLK_PERIOD_NS;

    // --------------------------------------------------------------
    // Host Wishbone map (byte addresses, 32-bit words)
    // --------------------------------------------------------------
    localparam logic [7:0] WB_CMD_ADDR = 8'h00;
    localparam logic [7:0] WB_STATUS_ADDR = 8'h04;
    localparam logic [7:0] WB_IRQ_STATUS_ADDR = 8'h08;
    localparam logic [7:0] WB_IRQ_CLEAR_ADDR = 8'h0C;
    localparam logic [7:0] WB_IRQ_ENABLE_ADDR = 8'h10;
    localparam logic [7:0] WB_CTRL_ADDR = 8'h14;
    localparam int CMD_DATA_LSB = 4;
    localparam int CMD_WRITE_BIT = 8;
    localparam int STAT_BUSY_BIT = 8;
    localparam int STAT_INT_BIT = 9;
    localparam int STAT_CE_BIT = 10;
    localparam int IRQ_DONE_BIT = 0;
    localparam int IRQ_LINK_BIT = 1;
    localparam int IRQ_WIDTH = 2;
    localparam logic CE_RESET = 1'b0;

endpackage
`default_nettype wire

// [pkg/rtc_link_if.sv]
`timescale 1ns/1ns
`default_nettype none
interface rtc_link_if;
    logic chip_enable;
    logic [3:0] addr;
    logic wr_en;
    logic rd_en;
    logic [3:0] wdata;
    logic [3:0] rdata;
    logic interrupt_out_n;

    modport device (
        input chip_enable, addr, wr_en, rd_en, wdata,
        output rdata, interrupt_out_n
    );
    modport host (
        output chip_enable, addr, wr_en, rd_en, wdata,
        input rdata, interrupt_out_n
    );
endinterface
`default_nettype wire

// [verilog/rtc_status_ctrl.sv]
// Notes on behaviour
// (R1) Status at Eh: busy, periodic, alarm, osc-stop.
// (R2) Osc-stop flag sticky; host clears by writing 0.
// (R3) Oscillator stop clears timer clock select MSB.
// (R4) Enabled alarm match sets flag, interrupt low.
// (R5) Alarm flag cleared by disable or write 0.
// (R6) Periodic flag mirrors periodic interrupt output low.
// (R7) Pulse mode ignores writes; level mode write-0 clears.
// (R8) Busy reads 1 during carry or reset pulse.
// (R9) Host avoids counter access while busy.
// (R10) Busy on adjust, correction, second carry, divider reset.
// (R11) Control at Fh: test bits, divider reset; reads 0.
// (R12) Divider reset write clears 8Hz..1Hz stages.
// (R13) Busy after divider reset at most 122.1us.
// (R14) Test bits 1 normal; forced 1 when chip disabled.
// (R15) Alarm disable releases alarm interrupt.
//
// Our own choice: the Wishbone slave port.
`timescale 1ns/1ns
`default_nettype none
module rtc_status_ctrl
    import rtc_regs_pkg::*;
#(
    parameter int BUSY_CYCLES = BUSY_MAX_CYCLES,
    parameter int BUSY_W = 14
)
(
    input wire logic sys_clk_i,
    input wire logic reset_i,
    input wire logic clk_en_i,
    rtc_link_if.device link,
    input wire logic osc_stopped_i,
    input wire logic alarm_enable_i,
    input wire logic alarm_time_match_i,
    input wire logic periodic_active_i,
    input wire logic periodic_output_mode_bit_i,
    input wire logic count_carry_enable_i,
    input wire logic second_carry_i,
    input wire logic adjust_30s_i,
    output logic timer_clock_select_msb_clr_o,
    output logic subsecond_divider_reset_o,
    output logic test_select_a_o,
    output logic test_select_b_o,
    output logic counter_busy_o
);

    // --------------------------------------------------------------
    // Elaboration checks
    // --------------------------------------------------------------
    generate
        if (BUSY_CYCLES < 1 || BUSY_CYCLES >= (1 << BUSY_W))
        begin : g_bad_busy
            $error("BUSY_CYCLES does not fit the busy counter");
        end
    endgenerate

    localparam logic [BUSY_W-1:0] BUSY_LOAD = BUSY_W'(BUSY_CYCLES);
    localparam logic [BUSY_W-1:0] BUSY_IDLE = '0;

    // --------------------------------------------------------------
    // State
    // --------------------------------------------------------------
    logic osc_stop_flag_reg;
    logic alarm_match_flag_reg;
    logic periodic_irq_flag_reg;
    logic test_select_a_reg;
    logic test_select_b_reg;
    logic div_reset_reg;
    logic tmr_clr_reg;
    logic osc_stopped_reg;
    logic alarm_hit_reg;
    logic periodic_active_reg;
    logic carry_enable_reg;
    logic carry_pending_reg;
    logic [BUSY_W-1:0] busy_count_reg;
    logic [3:0] rdata_reg;

    // --------------------------------------------------------------
    // Decode
    // --------------------------------------------------------------
    wire ce = link.chip_enable;
    wire wr_status = ce & link.wr_en & (link.addr == STATUS_FLAGS_ADDR);
    wire wr_ctrl = ce & link.wr_en & (link.addr == DIV_TEST_ADDR);
    wire rd_status = ce & link.rd_en & (link.addr == STATUS_FLAGS_ADDR);
    wire counter_busy = (busy_count_reg != BUSY_IDLE);

    wire osc_stop_rise = osc_stopped_i & ~osc_stopped_reg;
    wire alarm_hit = alarm_enable_i & alarm_time_match_i;
    wire alarm_rise = alarm_hit & ~alarm_hit_reg;
    wire periodic_rise = periodic_active_i & ~periodic_active_reg;
    wire level_mode = periodic_output_mode_bit_i;

    // Host clear strobes: only a written 0 clears
    wire osc_clear = wr_status & ~link.wdata[OSC_STOP_BIT];
    wire alarm_clear = wr_status & ~link.wdata[ALARM_BIT];
    wire periodic_clear = wr_status & level_mode & ~link.wdata[PERIODIC_BIT]; // [R7]

    wire div_reset_req = wr_ctrl & link.wdata[DIV_RESET_BIT]; // [R12]
    // A carry held back while counting is off starts a busy window on enable
    wire carry_fix = count_carry_enable_i & ~carry_enable_reg & carry_pending_reg;
    wire busy_start = adjust_30s_i | carry_fix | second_carry_i | div_reset_req; // [R10]

    // --------------------------------------------------------------
    // Next-state logic
    // --------------------------------------------------------------
    // Set wins over clear so an event in the clearing cycle survives
    wire osc_stop_next = osc_stopped_i | (osc_stop_flag_reg & ~osc_clear); // [R2]
    wire alarm_next = alarm_rise | (alarm_match_flag_reg & alarm_enable_i & ~alarm_clear); // [R4] [R5] [R15]
    // Pulse mode follows the periodic output; level mode latches until written 0
    wire periodic_next = level_mode ?
        (periodic_rise | (periodic_irq_flag_reg & ~periodic_clear)) :
        periodic_active_i; // [R6] [R7]
    wire test_a_next = ~ce | (wr_ctrl ? link.wdata[TEST_A_BIT] : test_select_a_reg); // [R14]
    wire test_b_next = ~ce | (wr_ctrl ? link.wdata[TEST_B_BIT] : test_select_b_reg); // [R14]
    wire carry_pending_next = count_carry_enable_i ? 1'b0 :
        (carry_pending_reg | second_carry_i);

    logic [BUSY_W-1:0] busy_next;
    always_comb
    begin
        busy_next = busy_count_reg;
        if (busy_start)
        begin
            busy_next = BUSY_LOAD; // [R13]
        end
        else if (counter_busy)
        begin
            busy_next = busy_count_reg - 1'b1; // [R8]
        end
    end

    // Only the status word reads back; the control word and W/O bits read 0
    wire [3:0] status_word = {counter_busy, periodic_irq_flag_reg,
        alarm_match_flag_reg, osc_stop_flag_reg}; // [R1]
    wire [3:0] rdata_next = rd_status ? status_word : ZERO_NIBBLE; // [R11]

    // --------------------------------------------------------------
    // Flags
    // --------------------------------------------------------------
    always_ff @(posedge sys_clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            osc_stop_flag_reg <= 1'b0;
            alarm_match_flag_reg <= 1'b0;
            periodic_irq_flag_reg <= 1'b0;
        end
        else if (clk_en_i)
        begin
            osc_stop_flag_reg <= osc_stop_next;
            alarm_match_flag_reg <= alarm_next;
            periodic_irq_flag_reg <= periodic_next;
        end
    end

    // --------------------------------------------------------------
    // Control bits and strobes
    // --------------------------------------------------------------
    always_ff @(posedge sys_clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            test_select_a_reg <= TEST_SELECT_RESET;
            test_select_b_reg <= TEST_SELECT_RESET;
            div_reset_reg <= 1'b0;
            tmr_clr_reg <= 1'b0;
        end
        else if (clk_en_i)
        begin
            test_select_a_reg <= test_a_next;
            test_select_b_reg <= test_b_next;
            div_reset_reg <= div_reset_req; // [R12]
            tmr_clr_reg <= osc_stop_rise; // [R3]
        end
    end

    // --------------------------------------------------------------
    // Edge history and busy timer
    // --------------------------------------------------------------
    always_ff @(posedge sys_clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            osc_stopped_reg <= 1'b0;
            alarm_hit_reg <= 1'b0;
            periodic_active_reg <= 1'b0;
            carry_enable_reg <= 1'b0;
            carry_pending_reg <= 1'b0;
            busy_count_reg <= BUSY_IDLE;
        end
        else if (clk_en_i)
        begin
            osc_stopped_reg <= osc_stopped_i;
            alarm_hit_reg <= alarm_hit;
            periodic_active_reg <= periodic_active_i;
            carry_enable_reg <= count_carry_enable_i;
            carry_pending_reg <= carry_pending_next;
            busy_count_reg <= busy_next;
        end
    end

    // --------------------------------------------------------------
    // Read data
    // --------------------------------------------------------------
    always_ff @(posedge sys_clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            rdata_reg <= ZERO_NIBBLE;
        end
        else if (clk_en_i)
        begin
            rdata_reg <= rdata_next;
        end
    end

    // --------------------------------------------------------------
    // Outputs
    // --------------------------------------------------------------
    assign link.rdata = rdata_reg;
    // Interrupt low while either flag stands; flags are registered so no glitch
    assign link.interrupt_out_n = ~(alarm_match_flag_reg | periodic_irq_flag_reg); // [R4] [R6]
    assign timer_clock_select_msb_clr_o = tmr_clr_reg;
    assign subsecond_divider_reset_o = div_reset_reg;
    assign test_select_a_o = test_select_a_reg;
    assign test_select_b_o = test_select_b_reg;
    assign counter_busy_o = counter_busy;

endmodule // rtc_status_ctrl
`default_nettype wire

// [verilog/rtc_host_ctrl.sv]
`timescale 1ns/1ns
`default_nettype none
module rtc_host_ctrl
    import rtc_regs_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic reset_i,
    input wire logic clk_en_i,
    rtc_link_if.host link,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic irq_o
);

    typedef enum logic [1:0] {IDLE, ISSUE, CAPTURE} link_state_t;

    link_state_t state_reg;
    logic [3:0] addr_reg;
    logic [3:0] wdata_reg;
    logic write_reg;
    logic [3:0] rdata_reg;
    logic ce_reg;
    logic ack_reg;
    logic int_n_reg;
    logic [IRQ_WIDTH-1:0] irq_status_reg;
    logic [IRQ_WIDTH-1:0] irq_enable_reg;
    logic [31:0] dat_reg;

    // --------------------------------------------------------------
    // Wishbone decode
    // --------------------------------------------------------------
    wire wb_req = wb_cyc_i & wb_stb_i & ~ack_reg;
    wire wb_wr = wb_req & wb_we_i & wb_sel_i[0];
    wire wr_cmd = wb_wr & (wb_adr_i == WB_CMD_ADDR);
    wire wr_clear = wb_wr & (wb_adr_i == WB_IRQ_CLEAR_ADDR);
    wire wr_enable = wb_wr & (wb_adr_i == WB_IRQ_ENABLE_ADDR);
    wire wr_ctrl = wb_wr & (wb_adr_i == WB_CTRL_ADDR);
    wire link_busy = (state_reg != IDLE);
    // A command while a transfer runs or the chip is off is dropped
    wire start = wr_cmd & ~link_busy & ce_reg;
    wire done = (state_reg == CAPTURE);
    wire int_fall = int_n_reg & ~link.interrupt_out_n;

    wire [IRQ_WIDTH-1:0] irq_events = {int_fall, done};
    wire [IRQ_WIDTH-1:0] clear_bits = wr_clear ? wb_dat_i[IRQ_WIDTH-1:0] : '0;
    wire [IRQ_WIDTH-1:0] irq_status_next = irq_events | (irq_status_reg & ~clear_bits);

    wire [31:0] status_word = {21'h000000, ce_reg, ~link.interrupt_out_n, link_busy,
        4'h0, rdata_reg};
    wire [31:0] rd_word =
        (wb_adr_i == WB_CMD_ADDR) ? {23'h000000, write_reg, wdata_reg, addr_reg} :
        (wb_adr_i == WB_STATUS_ADDR) ? status_word :
        (wb_adr_i == WB_IRQ_STATUS_ADDR) ? {30'h00000000, irq_status_reg} :
        (wb_adr_i == WB_IRQ_ENABLE_ADDR) ? {30'h00000000, irq_enable_reg} :
        (wb_adr_i == WB_CTRL_ADDR) ? {31'h00000000, ce_reg} : 32'h00000000;

    // --------------------------------------------------------------
    // Link sequencer
    // --------------------------------------------------------------
    link_state_t state_next;
    always_comb
    begin
        state_next = state_reg;
        unique case (state_reg)
            IDLE: if (start) state_next = ISSUE;
            ISSUE: state_next = CAPTURE;
            CAPTURE: state_next = IDLE;
        endcase
    end

    always_ff @(posedge sys_clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            state_reg <= IDLE;
            addr_reg <= 4'h0;
            wdata_reg <= 4'h0;
            write_reg <= 1'b0;
            rdata_reg <= 4'h0;
        end
        else if (clk_en_i)
        begin
            state_reg <= state_next;
            if (start)
            begin
                addr_reg <= wb_dat_i[3:0];
                wdata_reg <= wb_dat_i[CMD_DATA_LSB+3:CMD_DATA_LSB];
                write_reg <= wb_dat_i[CMD_WRITE_BIT];
            end
            if (done & ~write_reg)
            begin
                rdata_reg <= link.rdata;
            end
        end
    end

    // --------------------------------------------------------------
    // Bus slave and interrupt registers
    // --------------------------------------------------------------
    always_ff @(posedge sys_clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            ce_reg <= CE_RESET;
            ack_reg <= 1'b0;
            dat_reg <= 32'h00000000;
            int_n_reg <= 1'b1;
            irq_status_reg <= '0;
            irq_enable_reg <= '0;
        end
        else if (clk_en_i)
        begin
            ack_reg <= wb_req;
            dat_reg <= wb_req ? rd_word : dat_reg;
            int_n_reg <= link.interrupt_out_n;
            irq_status_reg <= irq_status_next;
            if (wr_enable)
            begin
                irq_enable_reg <= wb_dat_i[IRQ_WIDTH-1:0];
            end
            if (wr_ctrl)
            begin
                ce_reg <= wb_dat_i[0];
            end
        end
    end

    // --------------------------------------------------------------
    // Outputs
    // --------------------------------------------------------------
    // The device is only ever offered one-cycle strobes in ISSUE
    assign link.chip_enable = ce_reg;
    assign link.addr = addr_reg;
    assign link.wdata = wdata_reg;
    assign link.wr_en = (state_reg == ISSUE) & write_reg;
    assign link.rd_en = (state_reg == ISSUE) & ~write_reg;
    assign wb_ack_o = ack_reg;
    assign wb_dat_o = dat_reg;
    assign irq_o = |(irq_status_reg & irq_enable_reg);

endmodule // rtc_host_ctrl
`default_nettype wire

// [dv/rtc_link_properties.sv]
`timescale 1ns/1ns
`default_nettype none
module rtc_link_properties
    import rtc_regs_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic reset_i,
    input wire logic chip_enable,
    input wire logic [3:0] addr,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [3:0] wdata,
    input wire logic [3:0] rdata,
    input wire logic interrupt_out_n
);
    // ----------------------------------------------------------
    // Link protocol and flag coherence
    // ----------------------------------------------------------
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (reset_i);

    wire logic status_rd = rd_en && chip_enable && (addr == STATUS_FLAGS_ADDR);
    wire logic ctrl_rd = rd_en && chip_enable && (addr == DIV_TEST_ADDR);

    a_rdata_after_read: assert property (rdata != ZERO_NIBBLE |-> $past(rd_en))
        else $error("read data seen without a read strobe");
    a_rdata_one_cycle: assert property ((rdata != ZERO_NIBBLE) && !rd_en |=> rdata == ZERO_NIBBLE)
        else $error("read data stood longer than one cycle");
    a_ctrl_reads_zero: assert property (ctrl_rd |=> rdata == ZERO_NIBBLE)
        else $error("control register read returned nonzero");
    a_released_flags_clear: assert property (status_rd && interrupt_out_n |=> rdata[2:1] == 2'b00)
        else $error("flag read as set while interrupt released");
    a_low_int_flagged: assert property (status_rd && !interrupt_out_n |=> rdata[2:1] != 2'b00)
        else $error("interrupt low with no flag set");
    a_strobe_spacing: assert property ((wr_en || rd_en) |=> !(wr_en || rd_en) [*2])
        else $error("link strobes closer than three cycles");
    a_strobe_exclusive: assert property (!(wr_en && rd_en))
        else $error("read and write strobes together");
    a_strobe_with_ce: assert property ((wr_en || rd_en) |-> chip_enable)
        else $error("link strobe with chip enable low");

    c_alarm_read: cover property (status_rd && !interrupt_out_n);
    c_ctrl_write: cover property (wr_en && addr == DIV_TEST_ADDR && wdata[1]);
    c_ctrl_read: cover property (ctrl_rd);
endmodule // rtc_link_properties
`default_nettype wire

// [dv/rtc_status_and_control_regs_tb.sv]
`timescale 1ns/1ns
`default_nettype none
`define check(what, exp, got) \
    begin \
        n_tests++; \
        if ((got) !== (exp)) \
        begin \
            $display("wrong value %s expected %0h seen %0h", what, exp, got); \
            miscompares++; \
        end \
    end
module rtc_status_and_control_regs_tb
    import rtc_regs_pkg::*;
;
    // Short busy count keeps every busy window observable
    localparam int BUSY_SIM = 20;
    logic sys_clk, rst, osc_stop, al_en, al_match, per_act, per_mode, carry_en, sec_carry, adj30;
    logic wb_cyc, wb_stb, wb_we, wb_ack, irq, msb_clr, div_rst, test_a, test_b, busy;
    logic [7:0] wb_adr;
    logic [31:0] wb_dat_w, wb_dat_r, rd;
    logic [3:0] wb_sel;
    logic clk_en;
    int miscompares = 0;
    int n_tests = 0;
    int msb_cnt = 0;
    int div_cnt = 0;
    int run = 0;
    int last_run = 0;

    rtc_link_if link ();
    rtc_status_ctrl #(.BUSY_CYCLES(BUSY_SIM), .BUSY_W(14)) u_rtc_status_ctrl (
        .sys_clk_i(sys_clk), .reset_i(rst), .clk_en_i(clk_en), .link(link),
        .osc_stopped_i(osc_stop), .alarm_enable_i(al_en), .alarm_time_match_i(al_match),
        .periodic_active_i(per_act), .periodic_output_mode_bit_i(per_mode),
        .count_carry_enable_i(carry_en), .second_carry_i(sec_carry), .adjust_30s_i(adj30),
        .timer_clock_select_msb_clr_o(msb_clr), .subsecond_divider_reset_o(div_rst),
        .test_select_a_o(test_a), .test_select_b_o(test_b), .counter_busy_o(busy));
    rtc_host_ctrl u_rtc_host_ctrl (
        .sys_clk_i(sys_clk), .reset_i(rst), .clk_en_i(clk_en), .link(link),
        .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
        .wb_dat_i(wb_dat_w), .wb_sel_i(wb_sel), .wb_dat_o(wb_dat_r), .wb_ack_o(wb_ack),
        .irq_o(irq));
    rtc_link_properties u_rtc_link_properties (
        .sys_clk_i(sys_clk), .reset_i(rst), .chip_enable(link.chip_enable), .addr(link.addr),
        .wr_en(link.wr_en), .rd_en(link.rd_en), .wdata(link.wdata), .rdata(link.rdata),
        .interrupt_out_n(link.interrupt_out_n));

    // ----------------------------------------------------------
    // Clock and monitors
    // ----------------------------------------------------------
    initial
    begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    always @(posedge sys_clk)
    begin
        if (msb_clr === 1'b1) msb_cnt++;
        if (div_rst === 1'b1) div_cnt++;
        if (busy === 1'b1) run++;
        else if (run != 0)
        begin
            last_run = run;
            run = 0;
        end
    end

    // ----------------------------------------------------------
    // Bus tasks
    // ----------------------------------------------------------
    // Waits as long as the slave needs; only the watchdog ends a hung wait
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_sel <= 4'hF;
        wb_adr <= a;
        wb_dat_w <= d;
        do
        begin
            @(posedge sys_clk);
        end
        while (wb_ack !== 1'b1);
        rd = wb_dat_r;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_we <= 1'b0;
        @(posedge sys_clk);
        `check("bus ack drop", 1'b0, wb_ack)
    endtask

    // A command while a transfer runs is dropped, so poll until the host end is idle or 20 reads pass
    task automatic link_op(input logic w, input logic [3:0] a, input logic [3:0] d);
        int n;
        n = 0;
        wb(1'b1, WB_CMD_ADDR, {23'h0, w, d, a});
        do
        begin
            wb(1'b0, WB_STATUS_ADDR, 32'h0);
            n++;
        end
        while (rd[STAT_BUSY_BIT] !== 1'b0 && n < 20);
    endtask

    task automatic dev_rd(input logic [3:0] a, input logic [3:0] exp, input string what);
        link_op(1'b0, a, 4'h0);
        `check(what, exp, rd[3:0])
    endtask

    // ----------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------
    task automatic t_reset;
        dev_rd(STATUS_FLAGS_ADDR, 4'h0, "status after reset");
        `check("test a idle", 1'b1, test_a)
        `check("test b idle", 1'b1, test_b)
    endtask

    task automatic t_osc;
        osc_stop <= 1'b1;
        repeat (4) @(posedge sys_clk);
        osc_stop <= 1'b0;
        `check("timer msb clear", 1, msb_cnt)
        dev_rd(STATUS_FLAGS_ADDR, 4'h1, "osc flag held");
        link_op(1'b1, STATUS_FLAGS_ADDR, 4'h1);
        dev_rd(STATUS_FLAGS_ADDR, 4'h1, "osc write one");
        link_op(1'b1, STATUS_FLAGS_ADDR, 4'h8);
        dev_rd(STATUS_FLAGS_ADDR, 4'h0, "osc clear busy kept");
    endtask

    task automatic t_alarm;
        wb(1'b1, WB_IRQ_ENABLE_ADDR, 32'h2);
        al_en <= 1'b1;
        al_match <= 1'b1;
        repeat (3) @(posedge sys_clk);
        `check("alarm int", 1'b0, link.interrupt_out_n)
        `check("host irq alarm", 1'b1, irq)
        dev_rd(STATUS_FLAGS_ADDR, 4'h2, "alarm flag");
        link_op(1'b1, STATUS_FLAGS_ADDR, 4'hD);
        dev_rd(STATUS_FLAGS_ADDR, 4'h0, "alarm write zero");
        al_match <= 1'b0;
        @(posedge sys_clk);
        al_match <= 1'b1;
        repeat (3) @(posedge sys_clk);
        `check("alarm int again", 1'b0, link.interrupt_out_n)
        al_en <= 1'b0;
        repeat (2) @(posedge sys_clk);
        `check("alarm disable int", 1'b1, link.interrupt_out_n)
        dev_rd(STATUS_FLAGS_ADDR, 4'h0, "alarm disabled flag");
        al_match <= 1'b0;
        wb(1'b1, WB_IRQ_CLEAR_ADDR, 32'h2);
        `check("host irq cleared", 1'b0, irq)
    endtask

    task automatic t_periodic;
        per_act <= 1'b1;
        repeat (3) @(posedge sys_clk);
        `check("pulse int", 1'b0, link.interrupt_out_n)
        link_op(1'b1, STATUS_FLAGS_ADDR, 4'h9);
        dev_rd(STATUS_FLAGS_ADDR, 4'h4, "pulse ignores write");
        per_act <= 1'b0;
        repeat (3) @(posedge sys_clk);
        dev_rd(STATUS_FLAGS_ADDR, 4'h0, "pulse released");
        per_mode <= 1'b1;
        per_act <= 1'b1;
        @(posedge sys_clk);
        per_act <= 1'b0;
        repeat (3) @(posedge sys_clk);
        dev_rd(STATUS_FLAGS_ADDR, 4'h4, "level latched");
        link_op(1'b1, STATUS_FLAGS_ADDR, 4'hB);
        dev_rd(STATUS_FLAGS_ADDR, 4'h0, "level cleared");
        `check("level int off", 1'b1, link.interrupt_out_n)
    endtask

    task automatic t_busy;
        // With the clock enable low a pulse must leave no trace
        clk_en <= 1'b0;
        adj30 <= 1'b1;
        @(posedge sys_clk);
        adj30 <= 1'b0;
        repeat (2) @(posedge sys_clk);
        `check("frozen busy", 1'b0, busy)
        clk_en <= 1'b1;
        @(posedge sys_clk);
        adj30 <= 1'b1;
        @(posedge sys_clk);
        adj30 <= 1'b0;
        dev_rd(STATUS_FLAGS_ADDR, 4'h8, "busy read");
        repeat (BUSY_SIM + 4) @(posedge sys_clk);
        `check("busy adjust", BUSY_SIM, last_run)
        dev_rd(STATUS_FLAGS_ADDR, 4'h0, "busy over");
        sec_carry <= 1'b1;
        @(posedge sys_clk);
        sec_carry <= 1'b0;
        repeat (BUSY_SIM + 4) @(posedge sys_clk);
        `check("busy carry", BUSY_SIM, last_run)
        carry_en <= 1'b0;
        sec_carry <= 1'b1;
        @(posedge sys_clk);
        sec_carry <= 1'b0;
        repeat (BUSY_SIM + 4) @(posedge sys_clk);
        last_run = 0;
        carry_en <= 1'b1;
        repeat (BUSY_SIM + 4) @(posedge sys_clk);
        `check("busy carry fix", BUSY_SIM, last_run)
        link_op(1'b1, DIV_TEST_ADDR, 4'h6);
        repeat (BUSY_SIM + 4) @(posedge sys_clk);
        `check("busy divider", BUSY_SIM, last_run)
        `check("divider pulse", 1, div_cnt)
        `check("test a set", 1'b0, test_a)
        `check("test b set", 1'b1, test_b)
        dev_rd(DIV_TEST_ADDR, 4'h0, "control reads");
        wb(1'b1, WB_CTRL_ADDR, 32'h0);
        repeat (2) @(posedge sys_clk);
        `check("test a forced", 1'b1, test_a)
        wb(1'b1, WB_CTRL_ADDR, 32'h1);
    endtask

    task automatic t_irq;
        wb(1'b1, WB_IRQ_ENABLE_ADDR, 32'h0);
        wb(1'b1, WB_IRQ_CLEAR_ADDR, 32'h3);
        link_op(1'b0, STATUS_FLAGS_ADDR, 4'h0);
        `check("irq masked", 1'b0, irq)
        wb(1'b0, WB_IRQ_STATUS_ADDR, 32'h0);
        `check("done status", 1'b1, rd[IRQ_DONE_BIT])
        wb(1'b1, WB_IRQ_ENABLE_ADDR, 32'h1);
        `check("irq raised", 1'b1, irq)
        wb(1'b1, WB_IRQ_CLEAR_ADDR, 32'h1);
        `check("irq cleared", 1'b0, irq)
        wb(1'b0, 8'h1C, 32'h0);
        `check("unmapped read", 32'h0, rd)
    endtask

    task finish_test;
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
        begin
            $display("No errors found");
        end
        else
        begin
            $display("Errors were found");
        end
        $finish;
    endtask

    initial
    begin
        repeat (40000) @(posedge sys_clk);
        miscompares++;
        finish_test;
    end

    initial
    begin
        rst = 1'b1;
        {osc_stop, al_en, al_match, per_act, per_mode, sec_carry, adj30} = 7'h0;
        carry_en = 1'b1;
        clk_en = 1'b1;
        {wb_cyc, wb_stb, wb_we} = 3'h0;
        wb_adr = 8'h00;
        wb_dat_w = 32'h0;
        wb_sel = 4'hF;
        repeat (8) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        wb(1'b1, WB_CTRL_ADDR, 32'h1);
        t_reset;
        t_osc;
        t_alarm;
        t_periodic;
        t_busy;
        t_irq;
        finish_test;
    end
endmodule // rtc_status_and_control_regs_tb
`default_nettype wire
